// ### rtl/bsf_pkg.sv
// Constants for the battery status flag bank: register map, field positions, reset values
package bsf_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned DATA_W = 32;

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_OPEN_WIRE = 16'h7F27;
  localparam logic [15:0] IDX_SWITCH    = 16'h7F2A;
  localparam logic [15:0] IDX_HEALTH    = 16'h7F2B;
  localparam logic [15:0] IDX_ATTACH    = 16'h7F2C;
  localparam logic [15:0] IDX_IRQ_STAT  = 16'h7F30;
  localparam logic [15:0] IDX_IRQ_MASK  = 16'h7F31;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned POS_CELL0_OPEN    = 0;
  localparam int unsigned POS_CHECK_ACTIVE  = 23;
  localparam int unsigned POS_PUMP_ON       = 7;
  localparam int unsigned POS_DRV_MOVING    = 4;  // Charge 4, discharge 5, standby 6
  localparam int unsigned POS_FET_TIMEOUT   = 3;
  localparam int unsigned POS_SWITCH_ON     = 0;  // Charge 0, discharge 1, standby 2
  localparam int unsigned POS_NVM_FAIL      = 6;
  localparam int unsigned POS_NVM_DONE      = 5;
  localparam int unsigned POS_SUPPLY_FAIL   = 2;  // Regulator 2, 3.3 V 3, core 4
  localparam int unsigned POS_SELFTEST      = 0;  // Undervoltage 0, overvoltage 1
  localparam int unsigned POS_CHARGER_SEEN  = 15;
  localparam int unsigned POS_LOAD_SEEN     = 14;
  localparam int unsigned POS_CHARGER_ERR   = 13;
  localparam int unsigned POS_LOAD_ERR      = 12;
  localparam int unsigned POS_PACK_ABOVE    = 10;

  // Interrupt status / mask bits
  localparam int unsigned IRQ_W             = 8;
  localparam int unsigned IRQ_OPEN_WIRE     = 0;
  localparam int unsigned IRQ_FET_TIMEOUT   = 1;
  localparam int unsigned IRQ_NVM_FAIL      = 2;
  localparam int unsigned IRQ_SUPPLY_FAIL   = 3;
  localparam int unsigned IRQ_SELFTEST_FAIL = 4;
  localparam int unsigned IRQ_CHARGER_SEEN  = 5;
  localparam int unsigned IRQ_LOAD_SEEN     = 6;
  localparam int unsigned IRQ_SETTLE_ERR    = 7;

  // ----------------------------------------------------------------
  // Reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_FLAG_WORD = 32'h0000_0000;
  localparam logic [7:0]  RST_IRQ       = 8'h00;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // Number of raw condition inputs passed through synchronisers
  localparam int unsigned SRC_W = 26;

endpackage

// ### rtl/bsf_flag_bank.sv
// Read-only status flag bank with AXI4-Lite slave and flag-rise interrupt
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module bsf_flag_bank (
  input  wire logic        core_clk,             // 40 MHz system clock
  input  wire logic        rst_n,                // Asynchronous reset, active low
  // Raw conditions from analog monitors (asynchronous)
  input  wire logic [4:0]  cell_open_wire_src,   // Open wire per cell 0..4
  input  wire logic        check_active_src,     // Periodic open-wire check running
  input  wire logic        pump_on_src,          // Charge pump operating
  input  wire logic [2:0]  drv_moving_src,       // Driver moving: [2] standby [1] dsg [0] chg
  input  wire logic        fet_timeout_src,      // Switch turn-on timed out
  input  wire logic [2:0]  switch_on_src,        // Switch on: [2] standby [1] dsg [0] chg
  input  wire logic        nvm_fail_src,         // Memory integrity check failed
  input  wire logic        nvm_done_src,         // Memory integrity check completed
  input  wire logic [2:0]  supply_fail_src,      // [2] core [1] rail_3p3 [0] regulator_input
  input  wire logic [1:0]  selftest_fail_src,    // [1] overvoltage [0] undervoltage
  input  wire logic        charger_seen_src,     // Charger attach detected
  input  wire logic        load_seen_src,        // Load attach detected
  input  wire logic        charger_err_src,      // Charger settling could not rise
  input  wire logic        load_err_src,         // Load settling could not fall
  input  wire logic        pack_above_src,       // Pack positive above top plus 100mV
  // AXI4-Lite slave
  input  wire logic [17:0] s_axi_awaddr,         // Write address
  input  wire logic        s_axi_awvalid,        // Write address valid
  output logic             s_axi_awready,        // Write address ready
  input  wire logic [31:0] s_axi_wdata,          // Write data
  input  wire logic [3:0]  s_axi_wstrb,          // Write byte strobes
  input  wire logic        s_axi_wvalid,         // Write data valid
  output logic             s_axi_wready,         // Write data ready
  output logic [1:0]       s_axi_bresp,          // Write response
  output logic             s_axi_bvalid,         // Write response valid
  input  wire logic        s_axi_bready,         // Write response ready
  input  wire logic [17:0] s_axi_araddr,         // Read address
  input  wire logic        s_axi_arvalid,        // Read address valid
  output logic             s_axi_arready,        // Read address ready
  output logic [31:0]      s_axi_rdata,          // Read data
  output logic [1:0]       s_axi_rresp,          // Read response
  output logic             s_axi_rvalid,         // Read data valid
  input  wire logic        s_axi_rready,         // Read data ready
  output logic             irq                   // Level interrupt, high while unmasked status set
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [25:0] src_raw;
  logic [25:0] sync_a;
  logic [25:0] sync_b;

  // Pack all asynchronous sources; order must match the unpack below
  assign src_raw = {cell_open_wire_src, check_active_src, pump_on_src, drv_moving_src,
                    fet_timeout_src, switch_on_src, nvm_fail_src, nvm_done_src,
                    supply_fail_src, selftest_fail_src, charger_seen_src, load_seen_src,
                    charger_err_src, load_err_src, pack_above_src};

  // Two flops per bit; the first stage feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < bsf_pkg::SRC_W; gi++) begin : g_sync
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= src_raw[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Unpack synchronised conditions
  // ----------------------------------------------------------------
  wire [4:0] s_open     = sync_b[25:21];
  wire       s_active   = sync_b[20];
  wire       s_pump     = sync_b[19];
  wire [2:0] s_moving   = sync_b[18:16];
  wire       s_timeout  = sync_b[15];
  wire [2:0] s_on       = sync_b[14:12];
  wire       s_nvm_fail = sync_b[11];
  wire       s_nvm_done = sync_b[10];
  wire [2:0] s_supply   = sync_b[9:7];
  wire [1:0] s_selftest = sync_b[6:5];
  wire       s_chg_seen = sync_b[4];
  wire       s_ld_seen  = sync_b[3];
  wire       s_chg_err  = sync_b[2];
  wire       s_ld_err   = sync_b[1];
  wire       s_pack     = sync_b[0];

  // ----------------------------------------------------------------
  // Flag words
  // ----------------------------------------------------------------
  logic [31:0] open_wire_word;
  logic [31:0] switch_word;
  logic [31:0] health_word;
  logic [31:0] attach_word;
  logic [31:0] next_open_wire_word;
  logic [31:0] next_switch_word;
  logic [31:0] next_health_word;
  logic [31:0] next_attach_word;

  // Compose words; bits not listed stay zero
  always_comb begin
    next_open_wire_word = bsf_pkg::RST_FLAG_WORD;
    next_switch_word    = bsf_pkg::RST_FLAG_WORD;
    next_health_word    = bsf_pkg::RST_FLAG_WORD;
    next_attach_word    = bsf_pkg::RST_FLAG_WORD;
    next_open_wire_word[bsf_pkg::POS_CELL0_OPEN]        = s_open[0];
    next_open_wire_word[bsf_pkg::POS_CELL0_OPEN+1 +: 4] = s_open[4:1];
    next_open_wire_word[bsf_pkg::POS_CHECK_ACTIVE]      = s_active;
    next_switch_word[bsf_pkg::POS_PUMP_ON]              = s_pump;
    next_switch_word[bsf_pkg::POS_DRV_MOVING +: 3]      = s_moving;
    next_switch_word[bsf_pkg::POS_FET_TIMEOUT]          = s_timeout;
    next_switch_word[bsf_pkg::POS_SWITCH_ON +: 3]       = s_on;
    next_health_word[bsf_pkg::POS_NVM_FAIL]             = s_nvm_fail;
    next_health_word[bsf_pkg::POS_NVM_DONE]             = s_nvm_done;
    next_health_word[bsf_pkg::POS_SUPPLY_FAIL +: 3]     = s_supply;
    next_health_word[bsf_pkg::POS_SELFTEST +: 2]        = s_selftest;
    next_attach_word[bsf_pkg::POS_CHARGER_SEEN]         = s_chg_seen;
    next_attach_word[bsf_pkg::POS_LOAD_SEEN]            = s_ld_seen;
    next_attach_word[bsf_pkg::POS_CHARGER_ERR]          = s_chg_err;
    next_attach_word[bsf_pkg::POS_LOAD_ERR]             = s_ld_err;
    next_attach_word[bsf_pkg::POS_PACK_ABOVE]           = s_pack;
  end

  // Flags follow their sources only; no bus path reaches them
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      open_wire_word <= bsf_pkg::RST_FLAG_WORD;
      switch_word    <= bsf_pkg::RST_FLAG_WORD;
      health_word    <= bsf_pkg::RST_FLAG_WORD;
      attach_word    <= bsf_pkg::RST_FLAG_WORD;
    end else begin
      open_wire_word <= next_open_wire_word;
      switch_word    <= next_switch_word;
      health_word    <= next_health_word;
      attach_word    <= next_attach_word;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt events: a flag going from 0 to 1
  // ----------------------------------------------------------------
  wire [31:0] rise_ow  = next_open_wire_word & ~open_wire_word;
  wire [31:0] rise_sw  = next_switch_word & ~switch_word;
  wire [31:0] rise_hl  = next_health_word & ~health_word;
  wire [31:0] rise_at  = next_attach_word & ~attach_word;
  wire [7:0]  irq_event;

  assign irq_event[bsf_pkg::IRQ_OPEN_WIRE]     = |rise_ow[4:0];
  assign irq_event[bsf_pkg::IRQ_FET_TIMEOUT]   = rise_sw[bsf_pkg::POS_FET_TIMEOUT];
  assign irq_event[bsf_pkg::IRQ_NVM_FAIL]      = rise_hl[bsf_pkg::POS_NVM_FAIL];
  assign irq_event[bsf_pkg::IRQ_SUPPLY_FAIL]   = |rise_hl[bsf_pkg::POS_SUPPLY_FAIL +: 3];
  assign irq_event[bsf_pkg::IRQ_SELFTEST_FAIL] = |rise_hl[bsf_pkg::POS_SELFTEST +: 2];
  assign irq_event[bsf_pkg::IRQ_CHARGER_SEEN]  = rise_at[bsf_pkg::POS_CHARGER_SEEN];
  assign irq_event[bsf_pkg::IRQ_LOAD_SEEN]     = rise_at[bsf_pkg::POS_LOAD_SEEN];
  assign irq_event[bsf_pkg::IRQ_SETTLE_ERR]    = rise_at[bsf_pkg::POS_CHARGER_ERR] |
                                                 rise_at[bsf_pkg::POS_LOAD_ERR];

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic        aw_held;
  logic        w_held;
  logic [17:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  // Address and data are taken in either order and held until both are here
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  wire        aw_fire  = s_axi_awvalid && s_axi_awready;
  wire        w_fire   = s_axi_wvalid && s_axi_wready;
  wire        do_write = (aw_held || aw_fire) && (w_held || w_fire);
  wire [17:0] wr_addr  = aw_held ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wr_data  = w_held ? w_data_q : s_axi_wdata;
  wire [3:0]  wr_strb  = w_held ? w_strb_q : s_axi_wstrb;
  wire [15:0] wr_idx   = wr_addr[17:2];  // Word index; byte lane bits dropped

  // Flag words accept writes with OKAY but never change
  wire wr_is_flag  = (wr_idx == bsf_pkg::IDX_OPEN_WIRE) || (wr_idx == bsf_pkg::IDX_SWITCH) ||
                     (wr_idx == bsf_pkg::IDX_HEALTH)    || (wr_idx == bsf_pkg::IDX_ATTACH);
  wire wr_is_stat  = (wr_idx == bsf_pkg::IDX_IRQ_STAT);
  wire wr_is_mask  = (wr_idx == bsf_pkg::IDX_IRQ_MASK);
  wire wr_mapped   = wr_is_flag || wr_is_stat || wr_is_mask;
  wire irq_lane_en = wr_strb[0];  // Interrupt fields live in byte 0

  // Hold one half while waiting for the other, then raise the response
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr_q    <= 18'h0_0000;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= bsf_pkg::RESP_OKAY;
    end else if (do_write) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? bsf_pkg::RESP_OKAY : bsf_pkg::RESP_SLVERR;
    end else begin
      if (aw_fire) begin
        aw_held   <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_held   <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  logic [7:0] irq_status;
  logic [7:0] irq_mask;

  wire [7:0] stat_clear = (do_write && wr_is_stat && irq_lane_en) ? wr_data[7:0] : 8'h00;

  // A new event in the clearing cycle wins over the write-one-to-clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= bsf_pkg::RST_IRQ;
      irq_mask   <= bsf_pkg::RST_IRQ;
    end else begin
      irq_status <= (irq_status & ~stat_clear) | irq_event;
      if (do_write && wr_is_mask && irq_lane_en) begin
        irq_mask <= wr_data[7:0];
      end
    end
  end

  // Registered so the pin is glitch free
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_status & ~stat_clear) | irq_event) & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  wire [15:0] rd_idx = s_axi_araddr[17:2];
  wire        rd_ow  = (rd_idx == bsf_pkg::IDX_OPEN_WIRE);
  wire        rd_sw  = (rd_idx == bsf_pkg::IDX_SWITCH);
  wire        rd_hl  = (rd_idx == bsf_pkg::IDX_HEALTH);
  wire        rd_at  = (rd_idx == bsf_pkg::IDX_ATTACH);
  wire        rd_st  = (rd_idx == bsf_pkg::IDX_IRQ_STAT);
  wire        rd_mk  = (rd_idx == bsf_pkg::IDX_IRQ_MASK);
  wire        rd_hit = rd_ow || rd_sw || rd_hl || rd_at || rd_st || rd_mk;
  logic [31:0] rd_word;

  // Address decode for reads; unmapped reads return zero
  always_comb begin
    if (rd_ow) begin
      rd_word = open_wire_word;
    end else if (rd_sw) begin
      rd_word = switch_word;
    end else if (rd_hl) begin
      rd_word = health_word;
    end else if (rd_at) begin
      rd_word = attach_word;
    end else if (rd_st) begin
      rd_word = {24'h00_0000, irq_status};
    end else if (rd_mk) begin
      rd_word = {24'h00_0000, irq_mask};
    end else begin
      rd_word = 32'h0000_0000;
    end
  end

  // One read outstanding; address accepted only while no data waits
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= bsf_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? bsf_pkg::RESP_OKAY : bsf_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ### verif/bsf_flag_bank_asserts.sv
// Concurrent checks on the flag bank bus answers and the switch status word
`timescale 1ns/1ps
module bsf_flag_bank_asserts (
  input wire logic        core_clk,        // Clock
  input wire logic        rst_n,           // Reset, active low
  input wire logic        pump_on_src,     // Pump source
  input wire logic [2:0]  drv_moving_src,  // Driver moving sources
  input wire logic        fet_timeout_src, // Timeout source
  input wire logic [2:0]  switch_on_src,   // Switch on sources
  input wire logic        s_axi_awvalid,   // Write address valid
  input wire logic        s_axi_awready,   // Write address ready
  input wire logic        s_axi_wvalid,    // Write data valid
  input wire logic        s_axi_wready,    // Write data ready
  input wire logic [1:0]  s_axi_bresp,     // Write response
  input wire logic        s_axi_bvalid,    // Write response valid
  input wire logic        s_axi_bready,    // Write response ready
  input wire logic [17:0] s_axi_araddr,    // Read address
  input wire logic        s_axi_arvalid,   // Read address valid
  input wire logic        s_axi_arready,   // Read address ready
  input wire logic [31:0] s_axi_rdata,     // Read data
  input wire logic [1:0]  s_axi_rresp,     // Read response
  input wire logic        s_axi_rvalid,    // Read data valid
  input wire logic        s_axi_rready     // Read data ready
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic [2:0]  up_cnt;
  wire  [7:0]  sw_src = {pump_on_src, drv_moving_src, fet_timeout_src, switch_on_src};
  wire         ar_go  = s_axi_arvalid && s_axi_arready;
  wire  [15:0] ar_idx = s_axi_araddr[17:2];
  wire         ar_map = ar_idx == bsf_pkg::IDX_OPEN_WIRE || ar_idx == bsf_pkg::IDX_SWITCH ||
                        ar_idx == bsf_pkg::IDX_HEALTH || ar_idx == bsf_pkg::IDX_ATTACH ||
                        ar_idx == bsf_pkg::IDX_IRQ_STAT || ar_idx == bsf_pkg::IDX_IRQ_MASK;

  // Cycles since reset; the flag words need the synchroniser pipe refilled first
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      up_cnt <= 3'h0;
    end else if (up_cnt != 3'h7) begin
      up_cnt <= up_cnt + 3'h1;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_switch_word: assert property (
    ar_go && ar_idx == bsf_pkg::IDX_SWITCH && up_cnt == 3'h7 && $stable(sw_src) &&
    $past(sw_src, 2) == sw_src && $past(sw_src, 3) == sw_src
    |=> s_axi_rdata == {24'h00_0000, $past(sw_src)}) else $error("switch word mismatch");
  a_unmapped_err: assert property (ar_go && !ar_map |=> s_axi_rresp == bsf_pkg::RESP_SLVERR &&
    s_axi_rdata == 32'h0000_0000) else $error("unmapped read not refused");
  a_read_answer: assert property (ar_go |=> s_axi_rvalid) else $error("read answer late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
    $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
    $stable(s_axi_bresp)) else $error("write answer dropped");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken");
  a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("aw or w taken while answer pending");

  c_switch_read: cover property (ar_go && ar_idx == bsf_pkg::IDX_SWITCH && up_cnt == 3'h7);
  c_unmapped: cover property (ar_go && !ar_map);
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind bsf_flag_bank bsf_flag_bank_asserts i_bsf_flag_bank_asserts (.*);

// ### verif/bsf_flag_bank_tb.sv
// Self-checking bench for the status flag bank
`timescale 1ns/1ps
module bsf_flag_bank_tb;
  logic        core_clk, rst_n, irq;
  logic [25:0] src;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [33:0] rd_q[$];
  logic [1:0]  wr_q[$];
  logic [15:0] idx_tab[4] = '{bsf_pkg::IDX_OPEN_WIRE, bsf_pkg::IDX_SWITCH,
                              bsf_pkg::IDX_HEALTH, bsf_pkg::IDX_ATTACH};
  int          ev_pos[8]  = '{0, 10, 14, 16, 19, 21, 22, 23};
  int          err_total, samples_checked;

  bsf_flag_bank i_bsf_flag_bank (
    .cell_open_wire_src (src[4:0]),
    .check_active_src   (src[5]),
    .pump_on_src        (src[6]),
    .drv_moving_src     (src[9:7]),
    .fet_timeout_src    (src[10]),
    .switch_on_src      (src[13:11]),
    .nvm_fail_src       (src[14]),
    .nvm_done_src       (src[15]),
    .supply_fail_src    (src[18:16]),
    .selftest_fail_src  (src[20:19]),
    .charger_seen_src   (src[21]),
    .load_seen_src      (src[22]),
    .charger_err_src    (src[23]),
    .load_err_src       (src[24]),
    .pack_above_src     (src[25]),
    .*
  );

  // Expected flag word with an OKAY answer, built bit by bit from the sources
  function automatic logic [33:0] word(input int k, input logic [25:0] s);
    case (k)
      0: word = {2'b00, 8'h00, s[5], 18'h0_0000, s[4:0]};
      1: word = {2'b00, 24'h00_0000, s[6], s[9:7], s[10], s[13:11]};
      2: word = {2'b00, 25'h0, s[14], s[15], s[18:16], s[20:19]};
      default: word = {2'b00, 16'h0000, s[21], s[22], s[23], s[24], 1'b0, s[25], 10'h000};
    endcase
  endfunction

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Bus master: request held until taken; ready stays high so it never drops and rises at once
  task automatic rd(input logic [15:0] idx, input logic [33:0] exp);
    rd_q.push_back(exp);
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_rvalid);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] exp);
    logic aw_done, w_done;
    wr_q.push_back(exp);
    aw_done = 1'b0;
    w_done  = 1'b0;
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (!s_axi_bvalid);
  endtask

  // Sources pass two synchroniser stages and the word register
  task automatic put(input logic [25:0] v);
    src <= v;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic check_all();
    for (int k = 0; k < 4; k++) rd(idx_tab[k], word(k, src));
  endtask

  // Interrupt line looked at away from the rising edge, once updates have landed
  task automatic irq_is(input logic v);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk({33'h0, irq}, {33'h0, v});
    @(posedge core_clk);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Answer monitor: each answer takes the oldest note of its kind
  always @(posedge core_clk) begin
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
    if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp}, {32'h0, wr_q.pop_front()});
  end

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Watchdog sized well beyond the few hundred cycles the tests need
  initial begin
    #500000;
    err_total++;
    give_verdict();
  end

  initial begin
    {rst_n, src, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    void'($urandom(32'hae860163));
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    check_all();
    rd(bsf_pkg::IDX_IRQ_STAT, 34'h0_0000_0000);
    rd(bsf_pkg::IDX_IRQ_MASK, 34'h0_0000_0000);
    $display("test 1 done: reset values");
    for (int i = 0; i < 14; i++) begin
      put(i == 0 ? '1 : i == 1 ? 26'h000_0000 : 26'($urandom()));
      check_all();
    end
    $display("test 2 done: flag words follow sources");
    for (int k = 0; k < 4; k++) wr(idx_tab[k], 32'hFFFF_FFFF, bsf_pkg::RESP_OKAY);
    check_all();
    $display("test 3 done: host writes ignored");
    rd(16'h7F2D, {bsf_pkg::RESP_SLVERR, 32'h0000_0000});
    rd(16'h7F28, {bsf_pkg::RESP_SLVERR, 32'h0000_0000});
    wr(16'h7F2D, 32'h0000_0001, bsf_pkg::RESP_SLVERR);
    $display("test 4 done: unmapped addresses");
    wr(bsf_pkg::IDX_IRQ_MASK, 32'h0000_0000, bsf_pkg::RESP_OKAY);
    for (int e = 0; e < 8; e++) begin
      put(26'h000_0000);
      wr(bsf_pkg::IDX_IRQ_STAT, 32'h0000_00FF, bsf_pkg::RESP_OKAY);
      put(26'h000_0001 << ev_pos[e]);
      irq_is(1'b0);
      rd(bsf_pkg::IDX_IRQ_STAT, 34'h0_0000_0001 << e);
    end
    wr(bsf_pkg::IDX_IRQ_MASK, 32'h0000_0080, bsf_pkg::RESP_OKAY);
    rd(bsf_pkg::IDX_IRQ_MASK, 34'h0_0000_0080);
    irq_is(1'b1);
    wr(bsf_pkg::IDX_IRQ_STAT, 32'h0000_0080, bsf_pkg::RESP_OKAY);
    irq_is(1'b0);
    rd(bsf_pkg::IDX_IRQ_STAT, 34'h0_0000_0000);
    $display("test 5 done: interrupt set, mask, clear");
    give_verdict();
  end
endmodule
